// ---- verilog/cvr_output_cfg.sv ----
// How it works
// - 16-bit words by command code, word transfers
// - ceiling writes clamp to 110% of strap
// - margin-up word is target during margin up
// - margin-down word is target during margin down
// - target ramps toward set point at rate
// - droop word gives load-line slope
// - loop-scale word holds sense gain
// - monitor-scale word holds divider factor
// - duty-ceiling word limits switching duty
// - frequency word sets switching rate, kHz
// - start converting when input reaches turn-on
// - stop converting when input falls to turn-off
// - interleave bits 11:8 are group id
// - interleave bits 7:4 are unit count
// - interleave bits 3:0 set phase position
// - phase locks to common sync pin
// - current offset added to current readings
// - over-voltage word sets fault threshold
// - mode bits 000 select linear output-voltage format
`timescale 1ns/100ps
`default_nettype none

module cvr_output_cfg #(
	parameter logic [6:0]  BUS_ADDR   = 7'h10,
	parameter logic [15:0] CAL_OFFSET = 16'h0000,
	parameter int          PERIOD_W   = 16
) (
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 nrst_in,
	// bus pins
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe_out,
	// operating inputs
	input  wire logic [15:0]          strap_vout_in,
	input  wire cvr_pkg::cvr_margin_t margin_in,
	input  wire logic [15:0]          nominal_in,
	input  wire logic                 ramp_step_in,
	input  wire logic [7:0]           vout_mode_in,
	input  wire logic [15:0]          vin_level_in,
	input  wire logic [15:0]          vout_sense_in,
	input  wire logic [15:0]          iout_raw_in,
	input  wire logic                 sync_pin_in,
	// configuration and derived state
	output cvr_pkg::cvr_cfg_t         cfg_out,
	output logic [15:0]               target_out,
	output logic                      vout_linear_out,
	output logic [4:0]                vout_exp_out,
	output logic                      converting_out,
	output logic                      ov_fault_out,
	output logic signed [47:0]        iout_corr_out,
	output logic                      phase_pulse_out,
	output logic                      sync_locked_out
);

	logic [2:0]            pins_s;
	logic                  scl_s;
	logic                  sda_s;
	logic                  sync_s;
	logic                  scl_d;
	logic                  sda_d;
	logic                  sync_d;
	logic                  start_c;
	logic                  stop_c;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  sync_rise;

	cvr_pkg::cvr_bus_st_t  bus_st;
	cvr_pkg::cvr_phase_t   phase;
	cvr_pkg::cvr_lookup_t  cmd_q;
	cvr_pkg::cvr_lookup_t  cmd_lk;
	logic [2:0]            bit_cnt;
	logic                  got8;
	logic [7:0]            rx_sh;
	logic [7:0]            tx_sh;
	logic                  acked;
	logic                  rd_mode;
	logic                  hi_sent;
	logic                  master_ack;
	logic [7:0]            wr_lo;
	logic [15:0]           rd_word;
	logic                  wr_stb;
	logic [3:0]            wr_idx;
	logic [15:0]           wr_data;
	logic                  byte_ack;
	logic [7:0]            next_tx;

	logic [15:0]           regs [cvr_pkg::NUM_WORDS];
	logic [15:0]           strap_q;
	logic                  strap_taken;
	logic [19:0]           ceil_lim;
	logic [15:0]           setpoint;

	logic [PERIOD_W-1:0]   per_cnt;
	logic [PERIOD_W-1:0]   period_q;
	logic                  edge_seen;
	logic                  fired;
	logic [PERIOD_W+3:0]   slot_now;
	logic [PERIOD_W+3:0]   slot_goal;

	cvr_sync #(
		.WIDTH (3)
	) u_sync (
		.clk_in   (clk_in),
		.nrst_in  (nrst_in),
		.async_in ({scl_in, sda_in, sync_pin_in}),
		.sync_out (pins_s)
	);

	assign scl_s  = pins_s[2];
	assign sda_s  = pins_s[1];
	assign sync_s = pins_s[0];

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
			sync_d <= 1'b1;
		end else begin
			scl_d  <= scl_s;
			sda_d  <= sda_s;
			sync_d <= sync_s;
		end
	end

	assign start_c   = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c    = scl_s & scl_d & ~sda_d & sda_s;
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign sync_rise = sync_s & ~sync_d;

	// per-byte acknowledge decision
	always_comb begin
		unique case (phase)
			cvr_pkg::PH_ADDR: byte_ack = (rx_sh[7:1] == BUS_ADDR) && (!rx_sh[0] || cmd_q.hit);
			cvr_pkg::PH_CMD:  byte_ack = cmd_lk.hit;
			cvr_pkg::PH_LO,
			cvr_pkg::PH_HI:   byte_ack = (cmd_q.idx != cvr_pkg::IDX_CUR);
			default:          byte_ack = 1'b0;
		endcase
	end

	assign next_tx = hi_sent ? cvr_pkg::READ_FILL : rd_word[15:8];
	assign cmd_lk = cvr_pkg::cvr_cmd_lookup(rx_sh);

	// bus byte engine; an open-drain line is only ever pulled low
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			bus_st     <= cvr_pkg::BS_IDLE;
			phase      <= cvr_pkg::PH_ADDR;
			cmd_q      <= '0;
			bit_cnt    <= 3'h0;
			got8       <= 1'b0;
			rx_sh      <= 8'h00;
			tx_sh      <= 8'h00;
			acked      <= 1'b0;
			rd_mode    <= 1'b0;
			hi_sent    <= 1'b0;
			master_ack <= 1'b0;
			wr_lo      <= 8'h00;
			rd_word    <= 16'h0000;
			wr_stb     <= 1'b0;
			wr_idx     <= 4'h0;
			wr_data    <= 16'h0000;
			sda_out    <= 1'b0;
			sda_oe_out <= 1'b0;
		end else begin
			wr_stb  <= 1'b0;
			sda_out <= 1'b0;
			if (start_c) begin
				bus_st     <= cvr_pkg::BS_RX;
				phase      <= cvr_pkg::PH_ADDR;
				bit_cnt    <= 3'h0;
				got8       <= 1'b0;
				sda_oe_out <= 1'b0;
			end else if (stop_c) begin
				bus_st     <= cvr_pkg::BS_IDLE;
				cmd_q.hit  <= 1'b0;
				sda_oe_out <= 1'b0;
			end else begin
				unique case (bus_st)
					cvr_pkg::BS_IDLE: begin
						sda_oe_out <= 1'b0;
					end
					cvr_pkg::BS_RX: begin
						if (scl_rise) begin
							rx_sh   <= {rx_sh[6:0], sda_s};
							bit_cnt <= bit_cnt + 3'h1;
							got8    <= (bit_cnt == 3'h7);
						end else if (scl_fall && got8) begin
							got8       <= 1'b0;
							acked      <= byte_ack;
							sda_oe_out <= byte_ack;
							bus_st     <= cvr_pkg::BS_ACK;
							if (byte_ack) begin
								unique case (phase)
									cvr_pkg::PH_ADDR: begin
										rd_mode <= rx_sh[0];
										rd_word <= regs[cmd_q.idx];
										phase   <= rx_sh[0] ? cvr_pkg::PH_DONE : cvr_pkg::PH_CMD;
									end
									cvr_pkg::PH_CMD: begin
										cmd_q <= cmd_lk;
										phase <= cvr_pkg::PH_LO;
									end
									cvr_pkg::PH_LO: begin
										wr_lo <= rx_sh;
										phase <= cvr_pkg::PH_HI;
									end
									default: begin
										wr_stb  <= 1'b1;
										wr_idx  <= cmd_q.idx;
										wr_data <= {rx_sh, wr_lo};
										phase   <= cvr_pkg::PH_DONE;
									end
								endcase
							end
						end
					end
					cvr_pkg::BS_ACK: begin
						if (scl_fall) begin
							bit_cnt <= 3'h0;
							if (!acked) begin
								bus_st     <= cvr_pkg::BS_IDLE;
								sda_oe_out <= 1'b0;
							end else if (rd_mode) begin
								bus_st     <= cvr_pkg::BS_TX;
								hi_sent    <= 1'b0;
								tx_sh      <= rd_word[7:0];
								sda_oe_out <= ~rd_word[7];
							end else begin
								bus_st     <= cvr_pkg::BS_RX;
								sda_oe_out <= 1'b0;
							end
						end
					end
					cvr_pkg::BS_TX: begin
						if (scl_fall) begin
							if (bit_cnt == 3'h7) begin
								sda_oe_out <= 1'b0;
								bus_st     <= cvr_pkg::BS_RACK;
								bit_cnt    <= 3'h0;
							end else begin
								tx_sh      <= {tx_sh[6:0], 1'b0};
								sda_oe_out <= ~tx_sh[6];
								bit_cnt    <= bit_cnt + 3'h1;
							end
						end
					end
					default: begin
						if (scl_rise) begin
							master_ack <= ~sda_s;
						end else if (scl_fall) begin
							if (master_ack) begin
								bus_st     <= cvr_pkg::BS_TX;
								hi_sent    <= 1'b1;
								tx_sh      <= next_tx;
								sda_oe_out <= ~next_tx[7];
							end else begin
								bus_st <= cvr_pkg::BS_IDLE;
							end
						end
					end
				endcase
			end
		end
	end

	// strap is caught once, after reset is released
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			strap_q     <= 16'h0000;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			strap_q     <= strap_vout_in;
			strap_taken <= 1'b1;
		end
	end

	assign ceil_lim = 20'((20'(strap_q) * cvr_pkg::CEIL_NUM) / cvr_pkg::CEIL_DEN);

	// word storage; the current offset word is factory set and never written
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < cvr_pkg::NUM_WORDS; i++) begin
				regs[i] <= (4'(i) == cvr_pkg::IDX_CUR) ? CAL_OFFSET : cvr_pkg::WORD_RESET;
			end
		end else if (wr_stb) begin
			if (wr_idx == cvr_pkg::IDX_CEIL && {4'h0, wr_data} > ceil_lim) begin
				regs[wr_idx] <= ceil_lim[15:0];
			end else begin
				regs[wr_idx] <= wr_data;
			end
		end
	end

	// registered copy so every output comes from a flop
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			cfg_out <= '0;
		end else begin
			cfg_out.ceiling      <= regs[cvr_pkg::IDX_CEIL];
			cfg_out.margin_up    <= regs[cvr_pkg::IDX_MUP];
			cfg_out.margin_down  <= regs[cvr_pkg::IDX_MDN];
			cfg_out.ramp_rate    <= regs[cvr_pkg::IDX_RAMP];
			cfg_out.load_line    <= regs[cvr_pkg::IDX_DROOP];
			cfg_out.loop_gain    <= regs[cvr_pkg::IDX_GAIN];
			cfg_out.sense_div    <= regs[cvr_pkg::IDX_DIV];
			cfg_out.duty_ceiling <= regs[cvr_pkg::IDX_DUTY];
			cfg_out.sw_rate      <= regs[cvr_pkg::IDX_FREQ];
			cfg_out.vin_on       <= regs[cvr_pkg::IDX_VON];
			cfg_out.vin_off      <= regs[cvr_pkg::IDX_VOFF];
			cfg_out.group_id     <= regs[cvr_pkg::IDX_ILV][cvr_pkg::ILV_GROUP_LSB +: cvr_pkg::ILV_FIELD_W];
			cfg_out.rails        <= regs[cvr_pkg::IDX_ILV][cvr_pkg::ILV_RAILS_LSB +: cvr_pkg::ILV_FIELD_W];
			cfg_out.position     <= regs[cvr_pkg::IDX_ILV][cvr_pkg::ILV_POS_LSB +: cvr_pkg::ILV_FIELD_W];
			cfg_out.cur_offset   <= regs[cvr_pkg::IDX_CUR];
			cfg_out.ov_limit     <= regs[cvr_pkg::IDX_OV];
		end
	end

	always_comb begin
		unique case (margin_in)
			cvr_pkg::MRG_UP:   setpoint = regs[cvr_pkg::IDX_MUP];
			cvr_pkg::MRG_DOWN: setpoint = regs[cvr_pkg::IDX_MDN];
			default:           setpoint = nominal_in;
		endcase
	end

	// one lsb per step pulse; the step generator paces itself from ramp_rate
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			target_out <= 16'h0000;
		end else if (ramp_step_in) begin
			if (target_out < setpoint) begin
				target_out <= target_out + 16'h0001;
			end else if (target_out > setpoint) begin
				target_out <= target_out - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			vout_linear_out <= 1'b0;
			vout_exp_out    <= 5'h00;
		end else begin
			vout_linear_out <= (vout_mode_in[7:cvr_pkg::MODE_SEL_LSB] == cvr_pkg::MODE_LINEAR);
			vout_exp_out    <= vout_mode_in[4:0];
		end
	end

	// hysteresis: on and off thresholds are compared in fixed point
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			converting_out <= 1'b0;
		end else if (!converting_out) begin
			converting_out <= cvr_pkg::cvr_lin_to_fix(vin_level_in)
				>= cvr_pkg::cvr_lin_to_fix(regs[cvr_pkg::IDX_VON]);
		end else if (cvr_pkg::cvr_lin_to_fix(vin_level_in) <= cvr_pkg::cvr_lin_to_fix(regs[cvr_pkg::IDX_VOFF])) begin
			converting_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			ov_fault_out  <= 1'b0;
			iout_corr_out <= 48'sh0000_0000_0000;
		end else begin
			ov_fault_out  <= (vout_sense_in >= regs[cvr_pkg::IDX_OV]);
			iout_corr_out <= cvr_pkg::cvr_lin_to_fix(iout_raw_in)
				+ cvr_pkg::cvr_lin_to_fix(regs[cvr_pkg::IDX_CUR]);
		end
	end

	// phase slot reached when count*rails passes position*period
	assign slot_now  = (PERIOD_W+4)'(per_cnt) * (PERIOD_W+4)'(cfg_out.rails);
	assign slot_goal = (PERIOD_W+4)'(period_q) * (PERIOD_W+4)'(cfg_out.position);

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			per_cnt         <= '0;
			period_q        <= '0;
			edge_seen       <= 1'b0;
			fired           <= 1'b0;
			phase_pulse_out <= 1'b0;
			sync_locked_out <= 1'b0;
		end else if (sync_rise) begin
			per_cnt         <= '0;
			period_q        <= per_cnt;
			edge_seen       <= 1'b1;
			sync_locked_out <= edge_seen && (per_cnt != '1);
			// position zero is the clock source and fires on the edge itself
			fired           <= (cfg_out.position == 4'h0);
			phase_pulse_out <= (cfg_out.position == 4'h0);
		end else begin
			phase_pulse_out <= 1'b0;
			if (per_cnt == '1) begin
				sync_locked_out <= 1'b0;
				edge_seen       <= 1'b0;
			end else begin
				per_cnt <= per_cnt + 1'b1;
			end
			if (sync_locked_out && !fired && cfg_out.rails != 4'h0 && slot_now >= slot_goal) begin
				fired           <= 1'b1;
				phase_pulse_out <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ---- inc/cvr_pkg.sv ----
package cvr_pkg;

	// command codes of the configuration words
	localparam int         NUM_WORDS    = 14;
	localparam logic [7:0] CMD_CEIL     = 8'h24;
	localparam logic [7:0] CMD_MUP      = 8'h25;
	localparam logic [7:0] CMD_MDN      = 8'h26;
	localparam logic [7:0] CMD_RAMP     = 8'h27;
	localparam logic [7:0] CMD_DROOP    = 8'h28;
	localparam logic [7:0] CMD_GAIN     = 8'h29;
	localparam logic [7:0] CMD_DIV      = 8'h2A;
	localparam logic [7:0] CMD_DUTY     = 8'h32;
	localparam logic [7:0] CMD_FREQ     = 8'h33;
	localparam logic [7:0] CMD_VON      = 8'h35;
	localparam logic [7:0] CMD_VOFF     = 8'h36;
	localparam logic [7:0] CMD_ILV      = 8'h37;
	localparam logic [7:0] CMD_CUR      = 8'h39;
	localparam logic [7:0] CMD_OV       = 8'h40;

	// storage index of each word, same order as the table below
	localparam logic [3:0] IDX_CEIL     = 4'h0;
	localparam logic [3:0] IDX_MUP      = 4'h1;
	localparam logic [3:0] IDX_MDN      = 4'h2;
	localparam logic [3:0] IDX_RAMP     = 4'h3;
	localparam logic [3:0] IDX_DROOP    = 4'h4;
	localparam logic [3:0] IDX_GAIN     = 4'h5;
	localparam logic [3:0] IDX_DIV      = 4'h6;
	localparam logic [3:0] IDX_DUTY     = 4'h7;
	localparam logic [3:0] IDX_FREQ     = 4'h8;
	localparam logic [3:0] IDX_VON      = 4'h9;
	localparam logic [3:0] IDX_VOFF     = 4'hA;
	localparam logic [3:0] IDX_ILV      = 4'hB;
	localparam logic [3:0] IDX_CUR      = 4'hC;
	localparam logic [3:0] IDX_OV       = 4'hD;

	localparam logic [7:0] CMD_TABLE [NUM_WORDS] = '{CMD_CEIL, CMD_MUP, CMD_MDN, CMD_RAMP, CMD_DROOP,
		CMD_GAIN, CMD_DIV, CMD_DUTY, CMD_FREQ, CMD_VON, CMD_VOFF, CMD_ILV, CMD_CUR, CMD_OV};

	localparam logic [15:0] WORD_RESET  = 16'h0000;
	localparam logic [7:0]  READ_FILL   = 8'hFF;

	// interleave word fields
	localparam int          ILV_GROUP_LSB = 8;
	localparam int          ILV_RAILS_LSB = 4;
	localparam int          ILV_POS_LSB   = 0;
	localparam int          ILV_FIELD_W   = 4;

	// output-voltage mode byte
	localparam int          MODE_SEL_LSB  = 5;
	localparam logic [2:0]  MODE_LINEAR   = 3'h0;

	// ceiling limit is strap * 11 / 10
	localparam logic [19:0] CEIL_NUM      = 20'h0_000B;
	localparam logic [19:0] CEIL_DEN      = 20'h0_000A;

	typedef enum logic [1:0] {
		MRG_NONE = 2'b00,
		MRG_UP   = 2'b01,
		MRG_DOWN = 2'b10
	} cvr_margin_t;

	typedef enum logic [2:0] {
		BS_IDLE = 3'b000,
		BS_RX   = 3'b001,
		BS_ACK  = 3'b010,
		BS_TX   = 3'b011,
		BS_RACK = 3'b100
	} cvr_bus_st_t;

	typedef enum logic [2:0] {
		PH_ADDR = 3'b000,
		PH_CMD  = 3'b001,
		PH_LO   = 3'b010,
		PH_HI   = 3'b011,
		PH_DONE = 3'b100
	} cvr_phase_t;

	typedef struct packed {
		logic       hit;
		logic [3:0] idx;
	} cvr_lookup_t;

	typedef struct packed {
		logic [15:0] ceiling;
		logic [15:0] margin_up;
		logic [15:0] margin_down;
		logic [15:0] ramp_rate;
		logic [15:0] load_line;
		logic [15:0] loop_gain;
		logic [15:0] sense_div;
		logic [15:0] duty_ceiling;
		logic [15:0] sw_rate;
		logic [15:0] vin_on;
		logic [15:0] vin_off;
		logic [3:0]  group_id;
		logic [3:0]  rails;
		logic [3:0]  position;
		logic [15:0] cur_offset;
		logic [15:0] ov_limit;
	} cvr_cfg_t;

	function automatic cvr_lookup_t cvr_cmd_lookup(input logic [7:0] cmd);
		cvr_lookup_t r;
		r.hit = 1'b0;
		r.idx = 4'h0;
		for (int i = 0; i < NUM_WORDS; i++) begin
			if (CMD_TABLE[i] == cmd) begin
				r.hit = 1'b1;
				r.idx = 4'(i);
			end
		end
		return r;
	endfunction

	// linear word to signed fixed point with 16 fraction bits
	function automatic logic signed [47:0] cvr_lin_to_fix(input logic [15:0] w);
		logic signed [47:0] m;
		logic [4:0]         sh;
		m  = {{37{w[10]}}, w[10:0]};
		sh = {~w[15], w[14:11]};
		return m <<< sh;
	endfunction

endpackage

// ---- verilog/cvr_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module cvr_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// asynchronous levels in, synchronous levels out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	// idle-high pins; reset to high so no false start is seen
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			stage1   <= '1;
			sync_out <= '1;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

`default_nettype wire

// ---- testbench/cvr_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module cvr_host_model #(
	parameter logic [6:0] ADDR = 7'h10,
	parameter int         Q    = 6
) (
	// clock
	input  wire logic clk_in,
	// bus pins, sda_out high means released
	output logic      scl_out,
	output logic      sda_out,
	input  wire logic sda_in
);
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	task automatic qwait(input int n);
		repeat (n * Q) @(posedge clk_in);
	endtask

	task automatic put_bit(input logic b);
		sda_out <= b;
		qwait(1);
		scl_out <= 1'b1;
		qwait(2);
		scl_out <= 1'b0;
		qwait(1);
	endtask

	task automatic get_bit(output logic b);
		sda_out <= 1'b1;
		qwait(1);
		scl_out <= 1'b1;
		qwait(1);
		b = sda_in;
		qwait(1);
		scl_out <= 1'b0;
		qwait(1);
	endtask

	// serves as start and repeated start
	task automatic start_cond();
		sda_out <= 1'b1;
		qwait(1);
		scl_out <= 1'b1;
		qwait(1);
		sda_out <= 1'b0;
		qwait(1);
		scl_out <= 1'b0;
		qwait(1);
	endtask

	task automatic stop_cond();
		sda_out <= 1'b0;
		qwait(1);
		scl_out <= 1'b1;
		qwait(1);
		sda_out <= 1'b1;
		qwait(2);
	endtask

	task automatic put_byte(input logic [7:0] v, output logic ack);
		logic n;
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(n);
		ack = !n;
	endtask

	task automatic get_byte(output logic [7:0] v, input logic last);
		for (int i = 7; i >= 0; i--) get_bit(v[i]);
		put_bit(last);
	endtask

	// low byte first, then high byte
	task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
		logic a0, a1, a2, a3;
		start_cond();
		put_byte({ADDR, 1'b0}, a0);
		put_byte(cmd, a1);
		put_byte(d[7:0], a2);
		put_byte(d[15:8], a3);
		stop_cond();
		ok = a0 & a1 & a2 & a3;
	endtask

	task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
		logic a0, a1, a2;
		start_cond();
		put_byte({ADDR, 1'b0}, a0);
		put_byte(cmd, a1);
		start_cond();
		put_byte({ADDR, 1'b1}, a2);
		get_byte(d[7:0], 1'b0);
		get_byte(d[15:8], 1'b1);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
endmodule

`default_nettype wire

// ---- testbench/cvr_output_cfg_sva.sv ----
`timescale 1ns/100ps
`default_nettype none

module cvr_output_cfg_sva (
	// clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 nrst_in,
	// watched ports
	input  wire logic                 scl_in,
	input  wire logic                 sda_out,
	input  wire logic                 sda_oe_out,
	input  wire logic [15:0]          strap_vout_in,
	input  wire cvr_pkg::cvr_margin_t margin_in,
	input  wire logic                 ramp_step_in,
	input  wire logic [7:0]           vout_mode_in,
	input  wire logic [15:0]          vin_level_in,
	input  wire logic [15:0]          vout_sense_in,
	input  wire cvr_pkg::cvr_cfg_t    cfg_out,
	input  wire logic [15:0]          target_out,
	input  wire logic                 vout_linear_out,
	input  wire logic [4:0]           vout_exp_out,
	input  wire logic                 converting_out,
	input  wire logic                 ov_fault_out,
	input  wire logic                 phase_pulse_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	logic [19:0] ceil_lim;
	assign ceil_lim = 20'(strap_vout_in) * cvr_pkg::CEIL_NUM / cvr_pkg::CEIL_DEN;

	property p_open_drain; sda_out == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda driven high");
	// sda must never move while scl is high
	property p_ack_edge; $changed(sda_oe_out) |-> !scl_in && !$past(scl_in); endproperty
	a_ack_edge: assert property (p_ack_edge) else $error("sda moved with scl high");
	property p_ceiling; 20'(cfg_out.ceiling) <= ceil_lim; endproperty
	a_ceiling: assert property (p_ceiling) else $error("ceiling above limit");
	property p_ramp_up;
		ramp_step_in && margin_in == cvr_pkg::MRG_UP && $stable(margin_in) && target_out < cfg_out.margin_up
			&& $stable(cfg_out.margin_up) |=> target_out == $past(target_out) + 16'h0001;
	endproperty
	a_ramp_up: assert property (p_ramp_up) else $error("margin up step wrong");
	property p_ramp_dn;
		ramp_step_in && margin_in == cvr_pkg::MRG_DOWN && $stable(margin_in) && target_out > cfg_out.margin_down
			&& $stable(cfg_out.margin_down) |=> target_out == $past(target_out) - 16'h0001;
	endproperty
	a_ramp_dn: assert property (p_ramp_dn) else $error("margin down step wrong");
	property p_mode;
		$past(nrst_in) |-> vout_linear_out == ($past(vout_mode_in[7:5]) == cvr_pkg::MODE_LINEAR)
			&& vout_exp_out == $past(vout_mode_in[4:0]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode decode wrong");
	property p_conv_on;
		$rose(converting_out) && $past(vin_level_in[15:11] == cfg_out.vin_on[15:11])
			|-> $signed($past(vin_level_in[10:0])) >= $signed($past(cfg_out.vin_on[10:0]));
	endproperty
	a_conv_on: assert property (p_conv_on) else $error("started below turn-on");
	property p_conv_off;
		$fell(converting_out) && $past(vin_level_in[15:11] == cfg_out.vin_off[15:11])
			|-> $signed($past(vin_level_in[10:0])) <= $signed($past(cfg_out.vin_off[10:0]));
	endproperty
	a_conv_off: assert property (p_conv_off) else $error("stopped above turn-off");
	property p_ov;
		$past(nrst_in) && $stable(cfg_out.ov_limit)
			|-> ov_fault_out == ($past(vout_sense_in) >= $past(cfg_out.ov_limit));
	endproperty
	a_ov: assert property (p_ov) else $error("over-voltage flag wrong");
	property p_phase; phase_pulse_out |=> !phase_pulse_out; endproperty
	a_phase: assert property (p_phase) else $error("phase pulse too long");

	c_ack: cover property ($rose(sda_oe_out));
	c_conv: cover property ($rose(converting_out));
	c_phase: cover property (phase_pulse_out);
endmodule

bind cvr_output_cfg cvr_output_cfg_sva u_sva (.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe_out(sda_oe_out), .strap_vout_in(strap_vout_in), .margin_in(margin_in),
	.ramp_step_in(ramp_step_in), .vout_mode_in(vout_mode_in), .vin_level_in(vin_level_in),
	.vout_sense_in(vout_sense_in), .cfg_out(cfg_out), .target_out(target_out),
	.vout_linear_out(vout_linear_out), .vout_exp_out(vout_exp_out), .converting_out(converting_out),
	.ov_fault_out(ov_fault_out), .phase_pulse_out(phase_pulse_out));

`default_nettype wire

// ---- testbench/cvr_output_cfg_test.sv ----
`timescale 1ns/100ps
`default_nettype none

module cvr_output_cfg_test;
	localparam logic [15:0] CAL   = 16'h0A5C;
	localparam logic [15:0] LIM   = 16'h1199;
	localparam logic [15:0] CV[3] = '{16'h1198, 16'h1199, 16'h119A};
	localparam logic [15:0] VI[5] = '{16'h0010, 16'h0030, 16'h0025, 16'h0020, 16'h002F};
	localparam logic        VE[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

	logic clk_in = 1'b0, nrst_in = 1'b0, ramp = 1'b0, sync_pin = 1'b0, host_scl, host_sda;
	cvr_pkg::cvr_margin_t margin = cvr_pkg::MRG_NONE;
	logic [7:0] mode = 8'h00;
	logic [15:0] vin = 16'h0000, sense = 16'h0000, target;
	logic sda_oe, lin, conv, ovf, pulse, locked;
	logic [4:0] vexp;
	logic [47:0] icorr;
	cvr_pkg::cvr_cfg_t cfg;
	wire logic sda_line;
	int mismatches = 0, n_checks = 0, cycles = 0, sync_cnt = 0;

	always #4 clk_in = ~clk_in;
	assign sda_line = host_sda & ~sda_oe;

	always @(posedge clk_in) begin
		sync_cnt <= sync_cnt + 1;
		if (sync_cnt % 32 == 31) sync_pin <= ~sync_pin;
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			mismatches = mismatches + 1;
			report_and_stop();
		end
	end

	cvr_host_model host (.clk_in(clk_in), .scl_out(host_scl), .sda_out(host_sda), .sda_in(sda_line));

	cvr_output_cfg #(.CAL_OFFSET(CAL)) dut (
		.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(host_scl), .sda_in(sda_line), .sda_out(),
		.sda_oe_out(sda_oe), .strap_vout_in(16'h1000), .margin_in(margin), .nominal_in(16'h0000),
		.ramp_step_in(ramp), .vout_mode_in(mode), .vin_level_in(vin), .vout_sense_in(sense),
		.iout_raw_in(16'h0001), .sync_pin_in(sync_pin), .cfg_out(cfg), .target_out(target),
		.vout_linear_out(lin), .vout_exp_out(vexp), .converting_out(conv), .ov_fault_out(ovf),
		.iout_corr_out(icorr), .phase_pulse_out(pulse), .sync_locked_out(locked));

	task automatic chk_w(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic chk_b(input string what, input logic exp, input logic got);
		chk_w(what, {15'h0000, exp}, {15'h0000, got});
	endtask

	task automatic steps(input int n);
		repeat (n) begin
			@(posedge clk_in) ramp <= 1'b1;
			@(posedge clk_in) ramp <= 1'b0;
			repeat (2) @(posedge clk_in);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		logic ok;
		logic [15:0] d, v;
		logic seen;
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk_w("ceiling after reset", 16'h0000, cfg.ceiling);
		chk_w("offset after reset", CAL, cfg.cur_offset);
		chk_w("current reading", 16'h04B9, icorr[31:16]);
		for (int i = 0; i < cvr_pkg::NUM_WORDS; i++) begin
			v = 16'h9000 | 16'(i * 'h0111);
			host.wr_word(cvr_pkg::CMD_TABLE[i], v, ok);
			chk_b("write ack", i != cvr_pkg::IDX_CUR, ok);
			host.rd_word(cvr_pkg::CMD_TABLE[i], d, ok);
			chk_b("read ack", 1'b1, ok);
			chk_w("read back", i == cvr_pkg::IDX_CEIL ? LIM : (i == cvr_pkg::IDX_CUR ? CAL : v), d);
		end
		chk_w("load line", 16'h9444, cfg.load_line);
		chk_w("loop gain", 16'h9555, cfg.loop_gain);
		chk_w("sense divider", 16'h9666, cfg.sense_div);
		chk_w("duty ceiling", 16'h9777, cfg.duty_ceiling);
		chk_w("switch rate", 16'h9888, cfg.sw_rate);
		chk_w("group", 16'h000B, 16'(cfg.group_id));
		chk_w("rails", 16'h000B, 16'(cfg.rails));
		chk_w("position", 16'h000B, 16'(cfg.position));
		foreach (CV[k]) begin
			host.wr_word(cvr_pkg::CMD_CEIL, CV[k], ok);
			host.rd_word(cvr_pkg::CMD_CEIL, d, ok);
			chk_w("ceiling", CV[k] > LIM ? LIM : CV[k], d);
		end
		host.wr_word(8'h30, 16'h1234, ok);
		chk_b("unmapped write ack", 1'b0, ok);
		host.rd_word(8'h30, d, ok);
		chk_b("unmapped read ack", 1'b0, ok);
		chk_w("unmapped data", 16'hFFFF, d);
		host.wr_word(cvr_pkg::CMD_ILV, 16'h0530, ok);
		chk_w("group", 16'h0005, 16'(cfg.group_id));
		chk_w("rails", 16'h0003, 16'(cfg.rails));
		chk_w("position", 16'h0000, 16'(cfg.position));
		host.wr_word(cvr_pkg::CMD_MUP, 16'h0005, ok);
		host.wr_word(cvr_pkg::CMD_MDN, 16'h0002, ok);
		margin <= cvr_pkg::MRG_UP;
		steps(8);
		chk_w("margin up target", 16'h0005, target);
		margin <= cvr_pkg::MRG_DOWN;
		steps(8);
		chk_w("margin down target", 16'h0002, target);
		host.wr_word(cvr_pkg::CMD_VON, 16'h0030, ok);
		host.wr_word(cvr_pkg::CMD_VOFF, 16'h0020, ok);
		foreach (VI[k]) begin
			vin <= VI[k];
			repeat (4) @(posedge clk_in);
			chk_b("converting", VE[k], conv);
		end
		host.wr_word(cvr_pkg::CMD_OV, 16'h0100, ok);
		sense <= 16'h00FF;
		repeat (3) @(posedge clk_in);
		chk_b("ov below", 1'b0, ovf);
		sense <= 16'h0100;
		repeat (3) @(posedge clk_in);
		chk_b("ov at limit", 1'b1, ovf);
		mode <= 8'h3F;
		repeat (2) @(posedge clk_in);
		chk_b("linear mode", 1'b0, lin);
		mode <= 8'h14;
		repeat (2) @(posedge clk_in);
		chk_b("linear mode", 1'b1, lin);
		chk_w("mode exponent", 16'h0014, 16'(vexp));
		seen = 1'b0;
		repeat (80) @(posedge clk_in) seen = seen | pulse;
		chk_b("phase pulse", 1'b1, seen);
		chk_b("sync locked", 1'b1, locked);
		report_and_stop();
	end
endmodule

`default_nettype wire
